// File: pkg/reload_timer_params.svh
// constants for the five-channel reload down-timer group
`ifndef RELOAD_TIMER_PARAMS_SVH
`define RELOAD_TIMER_PARAMS_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define NUM_CH        5
`define CNT_W         16
`define MODE_W        8
`define ADDR_W        8
`define DATA_W        32
`define PRE_W         9

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_START     8'h00
`define OFS_IRQ       8'h04
`define OFS_PIN       8'h08
`define OFS_CH_BASE   8'h20
`define OFS_CH_LAST   8'h44
`define CH_IDX_HI     5
`define CH_IDX_LO     3
`define DATA_SEL_BIT  2
`define PIN_IN_LSB    8

// ----------------------------------------------------------------
// mode register fields and reset values
// ----------------------------------------------------------------
`define MB_PULSE      2
`define MB_GATE_POL   3
`define MB_GATE_EN    4
`define MB_GATE_RLD   5
`define MB_SRC_HI     7
`define MB_SRC_LO     6
`define MODE_RST      8'h00
`define CNT_RST       16'h0000
`define CNT_ZERO      16'h0000
`define CNT_ONE       16'h0001

// ----------------------------------------------------------------
// count source dividers: tick when the masked prescaler bits are all ones
// ----------------------------------------------------------------
`define SRC_MASK0     9'h001
`define SRC_MASK1     9'h00F
`define SRC_MASK2     9'h03F
`define SRC_MASK3     9'h1FF
`define PRE_ONE       9'h001

`endif

// File: pkg/reload_timer_pkg.sv
// types shared by the reload down-timer group
`default_nettype none
`include "reload_timer_params.svh"

package reload_timer_pkg;

	// operating mode held in mode bits 1:0
	typedef enum logic [1:0] {
		MODE_TIMER   = 2'b00,
		MODE_EVENT   = 2'b01,
		MODE_ONESHOT = 2'b10,
		MODE_PWM     = 2'b11
	} timer_mode_t;

	// state of one channel
	typedef struct packed {
		logic [`CNT_W-1:0] counter;
		logic [`CNT_W-1:0] reload;
		logic              out_level;
		logic              gate_prev;
		logic              zero_evt;
	} chan_state_t;

	// state of the register file and prescaler
	typedef struct packed {
		logic [`PRE_W-1:0]                 prescale;
		logic [`NUM_CH-1:0]                start;
		logic [`NUM_CH-1:0]                irq;
		logic [`NUM_CH-1:0][`MODE_W-1:0]   mode;
		logic [`DATA_W-1:0]                rdata;
		logic                              slverr;
	} top_state_t;

endpackage : reload_timer_pkg
`default_nettype wire

// File: rtl/timer_channel.sv
// one down-counting reload timer channel with pulse output and gate
`timescale 1ns/100ps
`default_nettype none
`include "reload_timer_params.svh"

module timer_channel
	import reload_timer_pkg::*;
(
	// clock and reset
	input  wire logic                pclk,
	input  wire logic                presetn,
	// control
	input  wire logic [`MODE_W-1:0]  mode,
	input  wire logic                start,
	input  wire logic                tick,
	input  wire logic                wr_stb,
	input  wire logic [`CNT_W-1:0]   wr_data,
	// pins
	input  wire logic                in_pin,
	output logic                     out_pin,
	output logic                     out_pin_en,
	// status
	output logic [`CNT_W-1:0]        count,
	output logic                     zero_evt
);

	chan_state_t st;
	chan_state_t next_st;
	logic        timer_mode;
	logic        gate_en;
	logic        gate_level;
	logic        run;
	logic        restart;
	logic        step;

	// next-state logic: count, reload, toggle, gate
	always_comb begin
		next_st    = st;
		next_st.zero_evt = 1'b0;
		timer_mode = (timer_mode_t'(mode[1:0]) == MODE_TIMER);
		gate_en    = mode[`MB_GATE_EN];
		gate_level = mode[`MB_GATE_POL] ? in_pin : ~in_pin;
		run        = start & timer_mode & (~gate_en | gate_level);
		restart    = run & gate_en & mode[`MB_GATE_RLD] & ~st.gate_prev;
		step       = tick & run;
		if (tick) begin
			next_st.gate_prev = gate_en & gate_level;
		end
		if (step) begin
			if (restart) begin
				next_st.counter = st.reload;
			end else if (st.counter == `CNT_ZERO) begin
				next_st.counter   = st.reload;
				next_st.zero_evt  = 1'b1;
				next_st.out_level = ~st.out_level;
			end else begin
				next_st.counter = st.counter - `CNT_ONE;
			end
		end
		// a busy channel only takes the new value at its next reload
		if (wr_stb) begin
			next_st.reload = wr_data;
			if (!start) begin
				next_st.counter = wr_data;
			end
		end
		if (!start) begin
			next_st.out_level = 1'b0;
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign count      = st.counter;
	assign zero_evt   = st.zero_evt;
	assign out_pin    = st.out_level & start;
	assign out_pin_en = mode[`MB_PULSE];

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	reload_on_zero_a: assert property (step && !restart && st.counter == `CNT_ZERO |=>
		st.counter == $past(st.reload) && st.zero_evt) else $error("no reload at zero");
	count_down_a: assert property (step && !restart && st.counter != `CNT_ZERO && !wr_stb |=>
		st.counter == $past(st.counter) - `CNT_ONE) else $error("counter did not decrement");
	halt_hold_a: assert property (!start && !wr_stb |=> $stable(st.counter))
		else $error("halted counter moved");
	halted_write_a: assert property (wr_stb && !start |=> st.counter == $past(wr_data)
		&& st.reload == $past(wr_data)) else $error("halted write lost");
	busy_write_a: assert property (wr_stb && start && !step |=> $stable(st.counter)
		&& st.reload == $past(wr_data)) else $error("busy write hit counter");
	toggle_on_zero_a: assert property (start ##1 (st.zero_evt && start) |->
		st.out_level != $past(st.out_level)) else $error("output did not toggle");
	out_low_halt_a: assert property ($fell(start) |-> !out_pin ##1 !st.out_level)
		else $error("output not low when halted");
	gate_hold_a: assert property (tick && gate_en && !gate_level && !wr_stb |=>
		$stable(st.counter)) else $error("counted with gate closed");
	gate_reload_a: assert property (step && restart && !wr_stb |=>
		st.counter == $past(st.reload)) else $error("no reload on gate restart");
	gate_restart_c: cover property (step && restart);

endmodule : timer_channel
`default_nettype wire

// File: rtl/reload_down_timer_with_gate.sv
// five-channel reload down-timer group with APB register access
//
// Summary of operation
// - eight 16-bit timers exist; this block is the five-channel group.
// - mode bits 1:0 choose the mode; 00 is plain timer mode.
// - mode bits 3 to 5 set gating; bit 3 ignored while bit 4 is zero.
// - mode bits 7:6 pick the channel's count source clock.
// - a channel counts only while its count-start bit is one.
// - at zero: set the request bit, reload the counter, keep counting.
// - data written to a halted channel goes to reload and counter.
// - data written to a running channel goes to reload only.
// - reading the data register returns the live counter.
// - a loaded value n divides the count source by n plus one.
// - with mode bit 2 set, the output pin toggles at every zero.
// - halted with pulse output enabled, the output pin is low.
// - bit 2 clear frees the output pin; bit 4 clear frees the input pin.
// - bit 4 set: count only while the input pin is at the bit 3 level.
// - gate without reload resumes from the held value.
// - gate with reload reloads on each restart; first zero after n plus two.
`timescale 1ns/100ps
`default_nettype none
`include "reload_timer_params.svh"

module reload_down_timer_with_gate
	import reload_timer_pkg::*;
(
	// clock and reset
	input  wire logic                pclk,
	input  wire logic                presetn,
	// APB slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [`ADDR_W-1:0]  paddr,
	input  wire logic [`DATA_W-1:0]  pwdata,
	output logic      [`DATA_W-1:0]  prdata,
	output logic                     pready,
	output logic                     pslverr,
	// timer pins
	input  wire logic [`NUM_CH-1:0]  channel_input_pin,
	output logic      [`NUM_CH-1:0]  channel_output_pin,
	output logic      [`NUM_CH-1:0]  channel_output_pin_oe,
	output logic      [`NUM_CH-1:0]  channel_input_pin_used
);

	// ----------------------------------------------------------------
	// state and wiring
	// ----------------------------------------------------------------
	top_state_t                      st;
	top_state_t                      next_st;
	logic                            setup;
	logic                            access;
	logic                            hit_start;
	logic                            hit_irq;
	logic                            hit_pin;
	logic                            hit_ch;
	logic                            hit_data;
	logic      [`ADDR_W-1:0]         ch_off;
	logic      [2:0]                 ch_idx;
	logic      [`NUM_CH-1:0]         wr_data_stb;
	logic      [`NUM_CH-1:0]         src_tick;
	logic      [`NUM_CH-1:0]         zero_all;
	logic      [`NUM_CH-1:0][`CNT_W-1:0] count_all;
	logic      [`NUM_CH-1:0]         irq_clear;

	// count source taps from the shared prescaler
	function automatic logic tap(input logic [`PRE_W-1:0] pre,
	                             input logic [1:0] sel);
		logic [`PRE_W-1:0] mask;
		mask = `SRC_MASK0;
		case (sel)
			2'h0: mask = `SRC_MASK0;
			2'h1: mask = `SRC_MASK1;
			2'h2: mask = `SRC_MASK2;
			default: mask = `SRC_MASK3;
		endcase
		return (pre & mask) == mask;
	endfunction : tap

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	// setup and access phase of the APB transfer; writes land in access
	assign setup  = psel & ~penable;
	assign access = psel & penable;
	assign ch_off = paddr - `OFS_CH_BASE;
	assign ch_idx = ch_off[`CH_IDX_HI:`CH_IDX_LO];

	// one register per aligned word; the channel window is checked by range
	always_comb begin
		hit_start = 1'b0;
		hit_irq   = 1'b0;
		hit_pin   = 1'b0;
		hit_ch    = 1'b0;
		hit_data  = 1'b0;
		if (paddr[1:0] != 2'h0) begin
			hit_ch = 1'b0;
		end else if (paddr == `OFS_START) begin
			hit_start = 1'b1;
		end else if (paddr == `OFS_IRQ) begin
			hit_irq = 1'b1;
		end else if (paddr == `OFS_PIN) begin
			hit_pin = 1'b1;
		end else if (paddr >= `OFS_CH_BASE && paddr <= `OFS_CH_LAST) begin
			hit_ch   = 1'b1;
			hit_data = paddr[`DATA_SEL_BIT];
		end
	end

	// request bits clear when software writes a one
	assign irq_clear = (access & pwrite & hit_irq) ? pwdata[`NUM_CH-1:0] : '0;

	// ----------------------------------------------------------------
	// channels
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < `NUM_CH; gi = gi + 1) begin : gen_ch
			assign src_tick[gi] = tap(st.prescale,
				st.mode[gi][`MB_SRC_HI:`MB_SRC_LO]);
			assign wr_data_stb[gi] = access & pwrite & hit_ch & hit_data
				& (ch_idx == 3'(gi));
			assign channel_input_pin_used[gi] = st.mode[gi][`MB_GATE_EN];

			timer_channel u_ch (
				.pclk       (pclk),
				.presetn    (presetn),
				.mode       (st.mode[gi]),
				.start      (st.start[gi]),
				.tick       (src_tick[gi]),
				.wr_stb     (wr_data_stb[gi]),
				.wr_data    (pwdata[`CNT_W-1:0]),
				.in_pin     (channel_input_pin[gi]),
				.out_pin    (channel_output_pin[gi]),
				.out_pin_en (channel_output_pin_oe[gi]),
				.count      (count_all[gi]),
				.zero_evt   (zero_all[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// register file next state
	// ----------------------------------------------------------------
	// read data is sampled in the setup cycle so prdata comes from a flop;
	// the counter value shown is the one at the setup edge
	always_comb begin
		next_st = st;
		next_st.prescale = st.prescale + `PRE_ONE;
		// a zero event in the same cycle as a clear keeps the bit set
		next_st.irq = (st.irq & ~irq_clear) | zero_all;
		if (access && pwrite) begin
			if (hit_start) begin
				next_st.start = pwdata[`NUM_CH-1:0];
			end else if (hit_ch && !hit_data) begin
				next_st.mode[ch_idx] = pwdata[`MODE_W-1:0];
			end
		end
		if (setup) begin
			next_st.rdata  = '0;
			next_st.slverr = 1'b0;
			if (pwrite) begin
				next_st.slverr = ~(hit_start | hit_irq | hit_pin | hit_ch);
			end else if (hit_start) begin
				next_st.rdata[`NUM_CH-1:0] = st.start;
			end else if (hit_irq) begin
				next_st.rdata[`NUM_CH-1:0] = st.irq;
			end else if (hit_pin) begin
				next_st.rdata[`NUM_CH-1:0] = channel_output_pin;
				next_st.rdata[`PIN_IN_LSB +: `NUM_CH] = channel_input_pin;
			end else if (hit_ch && hit_data) begin
				next_st.rdata[`CNT_W-1:0] = count_all[ch_idx];
			end else if (hit_ch) begin
				next_st.rdata[`MODE_W-1:0] = st.mode[ch_idx];
			end else begin
				next_st.slverr = 1'b1;
			end
		end
	end

	// state register; reset halts every channel
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// bus outputs
	// ----------------------------------------------------------------
	// zero wait states: the setup cycle has already prepared the answer
	assign pready  = 1'b1;
	assign prdata  = st.rdata;
	assign pslverr = st.slverr & access;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	irq_set_a: assert property ((zero_all != '0) |=>
		(st.irq & $past(zero_all)) == $past(zero_all)) else $error("request bit not set");
	start_write_a: assert property (access && pwrite && hit_start |=>
		st.start == $past(pwdata[`NUM_CH-1:0])) else $error("start bits not written");
	read_count_a: assert property (setup && !pwrite && hit_ch && hit_data |=>
		prdata[`CNT_W-1:0] == $past(count_all[ch_idx])) else $error("wrong counter read");
	mode_write_a: assert property (access && pwrite && hit_ch && !hit_data |=>
		st.mode[$past(ch_idx)] == $past(pwdata[`MODE_W-1:0])) else $error("mode not written");
	halted_pin_a: assert property ((st.start == '0) |->
		channel_output_pin == '0) else $error("output high while halted");

	zero_event_c: cover property (zero_all[0]);
	irq_clear_c: cover property (access && pwrite && hit_irq && st.irq != '0);
	read_data_c: cover property (setup && !pwrite && hit_data ##1 prdata != '0);

endmodule : reload_down_timer_with_gate
`default_nettype wire

// File: dv/gate_source_model.sv
// external gate signal source driving the timer input pins
`timescale 1ns/100ps
`default_nettype none
`include "reload_timer_params.svh"

module gate_source_model #(
	parameter int MIN_HOLD = 4
) (
	// clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// requested and driven levels
	input  wire logic [`NUM_CH-1:0] want,
	output logic      [`NUM_CH-1:0] level
);
	logic [7:0] held [`NUM_CH];

	// a level change waits until the old level has stood long enough
	always_ff @(posedge pclk or negedge presetn) begin
		for (int i = 0; i < `NUM_CH; i++) begin
			if (!presetn) begin
				level[i] <= 1'b0;
				held[i]  <= 8'h00;
			end else if (want[i] !== level[i] && held[i] >= 8'(MIN_HOLD)) begin
				level[i] <= want[i];
				held[i]  <= 8'h00;
			end else if (held[i] != 8'hFF) begin
				held[i] <= held[i] + 8'h01;
			end
		end
	end
endmodule : gate_source_model
`default_nettype wire

// File: dv/testbench.sv
// self-checking testbench for the five-channel reload timer group
`timescale 1ns/100ps
`default_nettype none
`include "reload_timer_params.svh"
`define CHECK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
	$display("ERROR %0t: got %0h expected %0h", $time, g, e); end end

module testbench;
	logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
	logic [`ADDR_W-1:0]   paddr;
	logic [`DATA_W-1:0]   pwdata, prdata, rd, v1;
	logic [`NUM_CH-1:0]   want, in_pins, out_pins, out_oe, in_used;
	int                   err_count, n_tests, clks;
	int                   div [4] = '{2, 16, 64, 512};

	reload_down_timer_with_gate u_reload_down_timer_with_gate (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .channel_input_pin(in_pins), .channel_output_pin(out_pins),
		.channel_output_pin_oe(out_oe), .channel_input_pin_used(in_used));
	gate_source_model u_gate_source_model (.pclk(pclk), .presetn(presetn),
		.want(want), .level(in_pins));

	// ----------------------------------------------------------------
	// clock, verdict and watchdog
	// ----------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	task automatic give_verdict();
		if (err_count == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : give_verdict

	// longest scenario is a few thousand clocks, so this is ample
	initial begin
		repeat (60000) @(posedge pclk);
		err_count++;
		give_verdict();
	end

	// ----------------------------------------------------------------
	// bus and timing helpers
	// ----------------------------------------------------------------
	// one APB transfer; the idle edge first avoids double drives, and the
	// closing half cycle lets callers look at outputs once the write has settled
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd      = prdata;
		rd_err  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(negedge pclk);
	endtask : apb

	// clocks until the output pin of a channel next changes
	task automatic toggle(input int ch);
		logic p;
		p = out_pins[ch];
		clks = 0;
		while (out_pins[ch] === p) begin
			@(posedge pclk);
			clks++;
		end
	endtask : toggle

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		apb(1'b0, `OFS_START, '0);
		`CHECK(rd, 32'h0000_0000);
		apb(1'b0, `OFS_CH_BASE, '0);
		`CHECK(rd, 32'h0000_0000);
		`CHECK(out_pins, 5'h00);
		`CHECK(out_oe, 5'h00);
		apb(1'b0, 8'h10, '0);
		`CHECK(rd_err, 1'b1);
	endtask : t_reset

	// every count source, pulse output, request bit and stop
	task automatic t_sources();
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, 8'h24, 32'h2);
			apb(1'b0, 8'h24, '0);
			`CHECK(rd[15:0], 16'h0002);
			apb(1'b1, `OFS_CH_BASE, {24'h0, 2'(s), 6'h04});
			`CHECK(out_oe[0], 1'b1);
			apb(1'b1, `OFS_START, 32'h1);
			toggle(0);
			toggle(0);
			`CHECK(clks, 3 * div[s]);
			toggle(0);
			`CHECK(out_pins[0], 1'b1);
			apb(1'b1, `OFS_START, 32'h0);
			`CHECK(out_pins[0], 1'b0);
			apb(1'b0, `OFS_IRQ, '0);
			`CHECK(rd[0], 1'b1);
			apb(1'b1, `OFS_IRQ, 32'h1);
			apb(1'b0, `OFS_IRQ, '0);
			`CHECK(rd, 32'h0000_0000);
			apb(1'b0, 8'h24, '0);
			v1 = rd;
			apb(1'b0, 8'h24, '0);
			`CHECK(rd, v1);
		end
	endtask : t_sources

	// reload changes while running reach the counter at the next zero
	task automatic t_running_write();
		apb(1'b1, 8'h24, 32'h3);
		apb(1'b1, `OFS_CH_BASE, 32'h04);
		apb(1'b1, `OFS_START, 32'h1);
		toggle(0);
		apb(1'b1, 8'h24, 32'h9);
		apb(1'b0, 8'h24, '0);
		`CHECK(rd[15:0] <= 16'h0003, 1'b1);
		toggle(0);
		toggle(0);
		`CHECK(clks, 20);
		apb(1'b1, `OFS_START, 32'h0);
	endtask : t_running_write

	// a mode other than timer mode must not count here
	task automatic t_other_mode();
		apb(1'b1, 8'h3C, 32'h4);
		apb(1'b1, 8'h38, 32'h01);
		apb(1'b1, `OFS_START, 32'h8);
		repeat (40) @(posedge pclk);
		apb(1'b0, 8'h3C, '0);
		`CHECK(rd[15:0], 16'h0004);
		apb(1'b1, `OFS_START, 32'h0);
	endtask : t_other_mode

	// active-low gate without reload holds the count while closed
	task automatic t_gate_hold();
		apb(1'b1, 8'h2C, 32'h5);
		apb(1'b1, 8'h28, 32'h14);
		`CHECK(in_used[1], 1'b1);
		apb(1'b1, `OFS_START, 32'h2);
		repeat (40) @(posedge pclk);
		apb(1'b0, 8'h2C, '0);
		`CHECK(rd[15:0], 16'h0005);
		want[1] <= 1'b0;
		toggle(1);
		`CHECK(clks >= 13 && clks <= 14, 1'b1);
		repeat (5) @(posedge pclk);
		want[1] <= 1'b1;
		repeat (20) @(posedge pclk);
		apb(1'b0, `OFS_PIN, '0);
		`CHECK(rd, 32'h0000_0202);
		apb(1'b0, 8'h2C, '0);
		v1 = rd;
		repeat (20) @(posedge pclk);
		apb(1'b0, 8'h2C, '0);
		`CHECK(rd, v1);
		apb(1'b1, `OFS_START, 32'h0);
	endtask : t_gate_hold

	// active-high gate with reload: n plus two, then n plus one
	task automatic t_gate_reload();
		apb(1'b1, 8'h34, 32'h4);
		apb(1'b1, 8'h30, 32'h3C);
		apb(1'b1, `OFS_START, 32'h4);
		repeat (20) @(posedge pclk);
		want[2] <= 1'b1;
		@(posedge pclk);
		while (in_pins[2] !== 1'b1) @(posedge pclk);
		toggle(2);
		`CHECK(clks >= 11 && clks <= 12, 1'b1);
		toggle(2);
		`CHECK(clks, 10);
		apb(1'b1, `OFS_START, 32'h0);
	endtask : t_gate_reload

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		err_count = 0;
		n_tests   = 0;
		presetn   = 1'b0;
		psel      = 1'b0;
		penable   = 1'b0;
		pwrite    = 1'b0;
		paddr     = '0;
		pwdata    = '0;
		want      = 5'h02;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_sources();
		t_running_write();
		t_other_mode();
		t_gate_hold();
		t_gate_reload();
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
